/* design/slsr_shifter.sv */
// serial-in parallel-out shift register with latched storage register
// Operation
// - eight-bit shifter feeds storage, storage drives outputs
// - separate clocks, each rising edge only
// - each register has own direct clear
// - shift clear low zeroes every shift stage
// - shift edge with data low loads zero
// - shift edge with data high loads one
// - later stages take preceding stage's old value
// - falling shift clock edge changes nothing
// - storage clear low zeroes all storage bits
// - storage edge captures shift contents in parallel
// - falling storage clock edge changes nothing
// - last shift stage drives cascade output
// - tied clocks: storage lags shifter one pulse
`timescale 1ns/10ps
`default_nettype none
`include "slsr_defs.svh"
module slsr_shifter
  import slsr_pkg::*;
#(
  parameter int WIDTH = `SLSR_WIDTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic shift_clock,
  input wire logic serial_data_in,
  input wire logic shift_clear_n,
  input wire logic storage_clock,
  input wire logic storage_clear_n,
  output logic [WIDTH-1:0] parallel_out,
  output logic serial_out,
  output logic capture_ready,
  output logic word_valid,
  output logic [WIDTH-1:0] word_data,
  input wire logic word_ready
);
  generate
    if (WIDTH < 2) begin : g_bad_width
      $error("slsr_shifter needs at least two stages");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // link domain: the shift register on the controller's shift clock

  typedef struct packed {
    logic [WIDTH-1:0] shift;
    logic tog;
  } slsr_link_t;

  slsr_link_t lk_r;
  slsr_link_t lk_nxt;

  always_comb begin
    lk_nxt = lk_r;
    lk_nxt.shift = {lk_r.shift[WIDTH-2:0], serial_data_in};
    // each shift edge flips the toggle so the core domain sees a new word
    lk_nxt.tog = !lk_r.tog;
  end

  // rising edge only, clear acts without the clock
  always_ff @(posedge shift_clock or negedge shift_clear_n) begin
    if (!shift_clear_n) begin
      lk_r <= {`SLSR_SHIFT_RESET, 1'b0};
    end else begin
      lk_r <= lk_nxt;
    end
  end

  assign serial_out = lk_r.shift[WIDTH-1];

  ////////////////////////////////////////////////////////////////////////
  // core domain: mirror of the shifter and storage clock edge detection

  typedef struct packed {
    slsr_sync_t clr;
    slsr_sync_t tog;
    slsr_sync_t sck;
    slsr_sync_t sclr;
    logic tog_seen;
    logic sck_prev;
    logic [WIDTH-1:0] mirror;
  } slsr_core_t;

  slsr_core_t cr_r;
  slsr_core_t cr_nxt;
  logic sck_rise;
  logic tog_evt;

  always_comb begin
    cr_nxt = cr_r;
    cr_nxt.clr.s1 = shift_clear_n;
    cr_nxt.clr.s2 = cr_r.clr.s1;
    cr_nxt.tog.s1 = lk_r.tog;
    cr_nxt.tog.s2 = cr_r.tog.s1;
    cr_nxt.sck.s1 = storage_clock;
    cr_nxt.sck.s2 = cr_r.sck.s1;
    // storage clear is a pin: only its synchronised copy gates the stream push
    cr_nxt.sclr.s1 = storage_clear_n;
    cr_nxt.sclr.s2 = cr_r.sclr.s1;
    cr_nxt.tog_seen = cr_r.tog.s2;
    cr_nxt.sck_prev = cr_r.sck.s2;
    sck_rise = cr_r.sck.s2 && !cr_r.sck_prev;
    tog_evt = cr_r.tog.s2 != cr_r.tog_seen;
    // the word is read only after its toggle has settled, on the third ref_clk edge after the shift edge
    if (!cr_r.clr.s2) begin
      cr_nxt.mirror = '0;
    end else if (tog_evt) begin
      cr_nxt.mirror = lk_r.shift;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cr_r <= '0;
    end else begin
      cr_r <= cr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // storage register: captures the mirror as it stood before the update

  logic [WIDTH-1:0] store_r;
  logic [WIDTH-1:0] store_nxt;

  // the mirror update and the capture land in one cycle, so the old word wins
  always_comb begin
    store_nxt = store_r;
    if (sck_rise) begin
      store_nxt = cr_r.mirror;
    end
  end

  always_ff @(posedge ref_clk or negedge storage_clear_n) begin
    if (!storage_clear_n) begin
      store_r <= `SLSR_STORE_RESET;
    end else if (rst) begin
      store_r <= `SLSR_STORE_RESET;
    end else begin
      store_r <= store_nxt;
    end
  end

  assign parallel_out = store_r;

  ////////////////////////////////////////////////////////////////////////
  // captured words also leave as a stream through the two-entry buffer while it has room; a capture into a full buffer is dropped

  slsr_buffer #(
    .WIDTH(WIDTH),
    .DEPTH(`SLSR_BUF_DEPTH)
  ) u_buf (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(sck_rise && cr_r.sclr.s2),
    .in_data(cr_r.mirror),
    .in_ready(capture_ready),
    .out_valid(word_valid),
    .out_data(word_data),
    .out_ready(word_ready)
  );
endmodule // slsr_shifter
`default_nettype wire

/* design/slsr_defs.svh */
// constants of the latched serial shifter
`ifndef SLSR_DEFS_SVH
`define SLSR_DEFS_SVH
`define SLSR_WIDTH 8
`define SLSR_BUF_DEPTH 2
`define SLSR_SYNC_STAGES 2
`define SLSR_SHIFT_RESET 8'h00
`define SLSR_STORE_RESET 8'h00
`endif

/* design/slsr_pkg.sv */
// types shared by the latched serial shifter files
package slsr_pkg;
  // stage of a two-flop synchroniser: first flop, second flop
  typedef struct packed {
    logic s1;
    logic s2;
  } slsr_sync_t;
endpackage

/* design/slsr_buffer.sv */
// two-entry valid/ready buffer with registered outputs
`timescale 1ns/10ps
`default_nettype none
`include "slsr_defs.svh"
module slsr_buffer
  import slsr_pkg::*;
#(
  parameter int WIDTH = `SLSR_WIDTH,
  parameter int DEPTH = `SLSR_BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  generate
    if (DEPTH != 2) begin : g_bad_depth
      $error("slsr_buffer supports exactly two entries");
    end
  endgenerate

  typedef struct packed {
    logic [WIDTH-1:0] head;
    logic head_v;
    logic [WIDTH-1:0] tail;
    logic tail_v;
    logic room;
  } slsr_buf_t;

  slsr_buf_t b_r;
  slsr_buf_t b_nxt;

  always_comb begin
    b_nxt = b_r;
    // pop first, so a buffer holding one word frees its head slot for a push in the same cycle
    if (b_r.head_v && out_ready) begin
      if (b_r.tail_v) begin
        b_nxt.head = b_r.tail;
        b_nxt.tail_v = 1'b0;
      end else begin
        b_nxt.head_v = 1'b0;
      end
    end
    if (in_valid && !b_r.tail_v) begin
      if (!b_nxt.head_v) begin
        b_nxt.head = in_data;
        b_nxt.head_v = 1'b1;
      end else begin
        b_nxt.tail = in_data;
        b_nxt.tail_v = 1'b1;
      end
    end
    // room is kept in a flop so the ready output needs no gate after it
    b_nxt.room = !b_nxt.tail_v;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      b_r <= '{head: '0, head_v: 1'b0, tail: '0, tail_v: 1'b0, room: 1'b1};
    end else begin
      b_r <= b_nxt;
    end
  end

  assign in_ready = b_r.room;
  assign out_valid = b_r.head_v;
  assign out_data = b_r.head;
endmodule // slsr_buffer
`default_nettype wire

/* verification/slsr_properties.sv */
// port assertions of the latched serial shifter
`timescale 1ns/10ps
`default_nettype none
module slsr_properties
  import slsr_pkg::*;
#(parameter int WIDTH = 8) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic shift_clock,
  input wire logic shift_clear_n,
  input wire logic storage_clock,
  input wire logic storage_clear_n,
  input wire logic [WIDTH-1:0] parallel_out,
  input wire logic serial_out,
  input wire logic capture_ready,
  input wire logic word_valid,
  input wire logic [WIDTH-1:0] word_data,
  input wire logic word_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_held; word_valid && $stable(word_data); endsequence
  property p_sclr; !shift_clear_n |-> !serial_out; endproperty
  a_sclr: assert property (p_sclr) else $error("cascade not cleared");
  property p_oclr; !storage_clear_n |-> parallel_out == '0; endproperty
  a_oclr: assert property (p_oclr) else $error("outputs not cleared");
  property p_cap; $changed(parallel_out) && storage_clear_n |-> $past(storage_clock, 3) || $past(storage_clock, 4);
  endproperty
  a_cap: assert property (p_cap) else $error("outputs moved without rise");
  property p_push; $changed(parallel_out) && storage_clear_n && $past(capture_ready) |-> word_valid; endproperty
  a_push: assert property (p_push) else $error("capture not queued");
  property p_first; $rose(word_valid) |-> word_data == parallel_out; endproperty
  a_first: assert property (p_first) else $error("word differs");
  property p_full; !capture_ready |-> word_valid; endproperty
  a_full: assert property (p_full) else $error("full yet empty");
  property p_stall; word_valid && !word_ready |=> s_held; endproperty
  a_stall: assert property (p_stall) else $error("word lost in stall");
  property p_ser; $changed(serial_out) |-> shift_clock || !shift_clear_n; endproperty
  a_ser: assert property (p_ser) else $error("cascade moved off rise");
  property p_noq; !storage_clear_n [*3] |=> !$rose(word_valid); endproperty
  a_noq: assert property (p_noq) else $error("queued while cleared");
endmodule // slsr_properties
bind slsr_shifter slsr_properties #(.WIDTH(WIDTH)) u_props (.*);
`default_nettype wire

/* verification/slsr_host.sv */
// controller model driving the shifter link
`timescale 1ns/10ps
`default_nettype none
module slsr_host (
  output logic shift_clock,
  output logic serial_data_in,
  output logic storage_clock,
  input wire logic serial_out
);
  logic tie = 0;
  logic [7:0] seen = '0;
  initial begin
    shift_clock = 0;
    serial_data_in = 0;
    storage_clock = 0;
  end
  task automatic send(input logic [7:0] d);
    #1.3;
    for (int i = 7; i >= 0; i--) begin
      serial_data_in = d[i];
      #32 seen = {seen[6:0], serial_out};
      shift_clock = 1;
      storage_clock = tie;
      #32 shift_clock = 0;
      storage_clock = 0;
      serial_data_in = ~d[i];
    end
  endtask
  task automatic store();
    #33.3 storage_clock = 1;
    #32 storage_clock = 0;
    #32;
  endtask
endmodule // slsr_host
`default_nettype wire

/* verification/tb_slsr_shifter.sv */
// self-checking bench of the latched serial shifter
`timescale 1ns/10ps
`default_nettype none
module tb_slsr_shifter;
  logic ref_clk = 0, rst = 1, shift_clear_n = 1, storage_clear_n = 1, word_ready = 0;
  logic shift_clock, serial_data_in, storage_clock, serial_out, capture_ready, word_valid;
  logic [7:0] parallel_out, word_data;
  int fail_count = 0, checks = 0;
  initial forever #2.5 ref_clk = ~ref_clk;
  slsr_host host (.shift_clock(shift_clock), .serial_data_in(serial_data_in), .storage_clock(storage_clock),
    .serial_out(serial_out));
  slsr_shifter dut (.ref_clk(ref_clk), .rst(rst), .shift_clock(shift_clock), .serial_data_in(serial_data_in),
    .shift_clear_n(shift_clear_n), .storage_clock(storage_clock), .storage_clear_n(storage_clear_n),
    .parallel_out(parallel_out), .serial_out(serial_out), .capture_ready(capture_ready),
    .word_valid(word_valid), .word_data(word_data), .word_ready(word_ready));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic pop();
    @(posedge ref_clk) word_ready <= 1;
    @(posedge ref_clk) word_ready <= 0;
    #1;
  endtask
  task automatic t_load_chain();
    host.send(8'hA5);
    host.store();
    check("out", parallel_out, 8'hA5);
    check("word", word_data, 8'hA5);
    pop();
    host.send(8'h3C);
    check("cascade", host.seen, 8'hA5);
    host.store();
    check("out", parallel_out, 8'h3C);
    pop();
  endtask
  task automatic t_stall();
    for (int i = 0; i < 3; i++) begin
      host.send(8'h01 << i);
      host.store();
    end
    check("ready", {7'h0, capture_ready}, 8'h00);
    check("out", parallel_out, 8'h04);
    check("word", word_data, 8'h01);
    pop();
    check("word", word_data, 8'h02);
    pop();
    check("valid", {7'h0, word_valid}, 8'h00);
  endtask
  task automatic t_clear();
    @(posedge ref_clk) storage_clear_n <= 0;
    shift_clear_n <= 0;
    #1 check("out", parallel_out, 8'h00);
    check("cascade", {7'h0, serial_out}, 8'h00);
    host.store();
    check("valid", {7'h0, word_valid}, 8'h00);
    @(posedge ref_clk) storage_clear_n <= 1;
    shift_clear_n <= 1;
    host.store();
    check("word", word_data, 8'h00);
    pop();
  endtask
  task automatic t_tie();
    host.tie = 1;
    host.send(8'hC3);
    host.tie = 0;
    #200 check("out", parallel_out, 8'h61);
  endtask
  initial begin
    // a real falling edge so the asynchronous clears load the shifter
    shift_clear_n <= 0;
    storage_clear_n <= 0;
    repeat (10) @(posedge ref_clk);
    rst <= 0;
    shift_clear_n <= 1;
    storage_clear_n <= 1;
    repeat (3) @(posedge ref_clk);
    t_load_chain();
    t_stall();
    t_clear();
    t_tie();
    test_done();
  end
  initial begin
    #40000;
    fail_count++;
    test_done();
  end
endmodule // tb_slsr_shifter
`default_nettype wire
